// >>> hw/asc_params.svh
// Offsets, field positions, reset values and timing counts of the converter sequencing control
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH

`define ASC_CTL_OFS      8'h00
`define ASC_DELAY_OFS    8'h04
`define ASC_STATUS_OFS   8'h08
`define ASC_SINGLE_OFS   8'h0C
`define ASC_REPEAT_OFS   8'h10

`define ASC_BIT_ACTIVATE 0
`define ASC_BIT_SSINGLE  1
`define ASC_BIT_SREPEAT  2
`define ASC_BIT_PSDIS    3
`define ASC_BIT_SOFTRST  4
`define ASC_BIT_RDONE    6
`define ASC_BIT_SDONE    7

`define ASC_START_DLY_LSB  0
`define ASC_REPEAT_DLY_LSB 16
`define ASC_REG_RESET      32'h0000_0000

`define ASC_CLK_PERIOD_NS  4
`define ASC_DELAY_UNIT_NS  40000
`define ASC_TICK_CYCLES    (`ASC_DELAY_UNIT_NS / `ASC_CLK_PERIOD_NS)

`endif

// >>> hw/asc_pkg.sv
// Types shared by the converter sequencing control
package asc_pkg;
  typedef enum logic [1:0] {
    ASC_IDLE,
    ASC_ISSUE,
    ASC_WAIT
  } asc_state_type;

  typedef struct packed {
    logic       reset;
    logic       power_up;
    logic       start;
    logic [3:0] channel;
  } asc_core_req_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } asc_bus_req_type;
endpackage

// >>> hw/asc_timer.sv
// Start delay and repeat interval timer counting in 40 us units
`timescale 1ns/1ps
`include "asc_params.svh"
module asc_timer #(
  parameter int TICK_CYCLES = `ASC_TICK_CYCLES,
  parameter int DW          = 16
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Control
  input  wire logic          run,
  input  wire logic [DW-1:0] start_delay,
  input  wire logic [DW-1:0] repeat_delay,
  // Request
  output logic               fire
);
  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam logic [PW-1:0] TICK_LAST = PW'(TICK_CYCLES - 1);

  logic          run_q;
  logic [PW-1:0] presc;
  logic [DW-1:0] units;

  wire rise     = run && !run_q;
  wire expired  = run && run_q && (units == '0);
  wire unit_end = (presc == TICK_LAST);

  always_ff @(posedge clk) begin
    if (rst) begin
      run_q <= 1'b0;
      presc <= '0;
      units <= '0;
      fire  <= 1'b0;
    end else begin
      run_q <= run;
      fire  <= expired;
      if (rise) begin
        units <= start_delay;
        presc <= '0;
      end else if (expired) begin
        units <= repeat_delay;
        presc <= '0;
      end else if (run) begin
        presc <= unit_end ? '0 : presc + PW'(1);
        if (unit_end) begin
          units <= units - DW'(1);
        end
      end
    end
  end
endmodule

// >>> hw/asc_ctrl.sv
// Converter sequencing control: register file, request arbitration and channel sequencer
`timescale 1ns/1ps
`include "asc_params.svh"
module asc_ctrl
  import asc_pkg::*;
#(
  parameter int CHANNELS    = 8,
  parameter int TICK_CYCLES = `ASC_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire asc_bus_req_type   bus,
  output logic [31:0]            rdata,
  // Converter core
  input  wire logic              conv_done,
  output asc_core_req_type       core,
  // Processor interrupt requests
  output logic                   single_irq,
  output logic                   repeat_irq
);
  // Control register fields
  logic                activate;
  logic                start_single;
  logic                start_repeat;
  logic                power_saver_dis;
  logic                soft_reset;
  logic                single_done;
  logic                repeat_done;
  // Other registers
  logic [15:0]         start_delay;
  logic [15:0]         repeat_delay;
  logic [CHANNELS-1:0] single_en;
  logic [CHANNELS-1:0] repeat_en;
  logic [CHANNELS-1:0] ch_status;
  // Sequencer
  asc_state_type       state;
  asc_state_type       next_state;
  logic                cur_repeat;
  logic [CHANNELS-1:0] remaining;
  logic [3:0]          cur_ch;
  logic                single_pend;
  logic                repeat_pend;
  logic                act_q;
  logic                timer_fire;
  logic [3:0]          last_ch;
  logic                last_seen;

  // Address decode
  wire wr_ctl    = bus.wr && (bus.addr == `ASC_CTL_OFS);
  wire wr_delay  = bus.wr && (bus.addr == `ASC_DELAY_OFS);
  wire wr_status = bus.wr && (bus.addr == `ASC_STATUS_OFS);
  wire wr_single = bus.wr && (bus.addr == `ASC_SINGLE_OFS);
  wire wr_repeat = bus.wr && (bus.addr == `ASC_REPEAT_OFS);

  wire [31:0] ctl_word = {24'h0000_00, single_done, repeat_done, 1'b0, soft_reset,
                          power_saver_dis, start_repeat, start_single, activate};
  wire [31:0] rd_mux =
    (bus.addr == `ASC_CTL_OFS)    ? ctl_word :
    (bus.addr == `ASC_DELAY_OFS)  ? {repeat_delay, start_delay} :
    (bus.addr == `ASC_STATUS_OFS) ? 32'(ch_status) :
    (bus.addr == `ASC_SINGLE_OFS) ? 32'(single_en) :
    (bus.addr == `ASC_REPEAT_OFS) ? 32'(repeat_en) : 32'h0000_0000;

  // Lowest enabled channel still to convert
  function automatic logic [3:0] lowest(input logic [CHANNELS-1:0] m);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (m[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Request arbitration and cycle events
  wire seq_go       = activate && !soft_reset;
  wire launch       = (state == ASC_IDLE) && seq_go && (single_pend || repeat_pend);
  wire take_single  = launch && single_pend;
  wire take_repeat  = launch && !single_pend;
  wire cycle_end    = (state == ASC_ISSUE) && (remaining == '0);
  wire single_end   = cycle_end && !cur_repeat;
  wire repeat_end   = cycle_end && cur_repeat;
  wire [3:0] low_ch = lowest(remaining);
  wire [CHANNELS-1:0] low_bit = CHANNELS'(1) << low_ch;
  wire issue        = (state == ASC_ISSUE) && (remaining != '0);
  wire w1_sdone     = wr_ctl && bus.wdata[`ASC_BIT_SDONE];
  wire w1_rdone     = wr_ctl && bus.wdata[`ASC_BIT_RDONE];
  // single start only with activate set
  wire single_req   = wr_ctl && bus.wdata[`ASC_BIT_SSINGLE] && bus.wdata[`ASC_BIT_ACTIVATE];

  wire next_single_done = (single_done && !w1_sdone && !take_single) || single_end;
  wire next_repeat_done = (repeat_done && !w1_rdone && !take_repeat) || repeat_end;
  // A start written together with activate pends before activate reads back
  wire next_single_pend = (seq_go && single_pend && !take_single) || (single_req && !bus.wdata[`ASC_BIT_SOFTRST]);
  // pending periodic request dropped once repeat mode is cleared
  wire next_repeat_pend = seq_go && start_repeat && ((repeat_pend && !take_repeat) || timer_fire);
  wire [CHANNELS-1:0] conv_bit = (conv_done && state == ASC_WAIT) ? CHANNELS'(1) << cur_ch : '0;
  wire [CHANNELS-1:0] next_status =
    (ch_status & ~(wr_status ? bus.wdata[CHANNELS-1:0] : '0)) | conv_bit;

  always_comb begin
    next_state = state;
    case (state)
      ASC_IDLE:  next_state = launch ? ASC_ISSUE : ASC_IDLE;
      ASC_ISSUE: next_state = (remaining == '0) ? ASC_IDLE : ASC_WAIT;
      ASC_WAIT:  next_state = conv_done ? ASC_ISSUE : ASC_WAIT;
      default:   next_state = ASC_IDLE;
    endcase
  end

  // periodic requests only while repeat mode and activate stand
  asc_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .DW          (16)
  ) u_timer (
    .clk          (clk),
    .rst          (rst),
    .run          (start_repeat && seq_go),
    .start_delay  (start_delay),
    .repeat_delay (repeat_delay),
    .fire         (timer_fire)
  );

  // Register file
  always_ff @(posedge clk) begin
    if (rst) begin
      {single_done, repeat_done, soft_reset, power_saver_dis} <= 4'h0;
      {start_repeat, start_single, activate}                  <= 3'h0;
      {repeat_delay, start_delay}                             <= `ASC_REG_RESET;
      single_en <= '0;
      repeat_en <= '0;
      ch_status <= '0;
      rdata     <= 32'h0000_0000;
    end else begin
      single_done <= next_single_done;
      repeat_done <= next_repeat_done;
      ch_status   <= next_status;
      rdata       <= bus.rd ? rd_mux : 32'h0000_0000;
      start_single <= single_req;
      if (wr_ctl) begin
        soft_reset      <= bus.wdata[`ASC_BIT_SOFTRST];
        power_saver_dis <= bus.wdata[`ASC_BIT_PSDIS];
        start_repeat    <= bus.wdata[`ASC_BIT_SREPEAT];
        activate        <= bus.wdata[`ASC_BIT_ACTIVATE];
      end
      if (wr_delay) begin
        start_delay  <= bus.wdata[`ASC_START_DLY_LSB +: 16];
        repeat_delay <= bus.wdata[`ASC_REPEAT_DLY_LSB +: 16];
      end
      if (wr_single) begin
        single_en <= bus.wdata[CHANNELS-1:0];
      end
      if (wr_repeat) begin
        repeat_en <= bus.wdata[CHANNELS-1:0];
      end
    end
  end

  // Channel sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state       <= ASC_IDLE;
      cur_repeat  <= 1'b0;
      remaining   <= '0;
      cur_ch      <= 4'h0;
      single_pend <= 1'b0;
      repeat_pend <= 1'b0;
    end else if (soft_reset) begin
      state       <= ASC_IDLE;
      remaining   <= '0;
      single_pend <= 1'b0;
      repeat_pend <= 1'b0;
    end else begin
      state       <= next_state;
      single_pend <= next_single_pend;
      repeat_pend <= next_repeat_pend;
      // single mask or repeat mask loaded at launch
      if (launch) begin
        cur_repeat <= take_repeat;
        remaining  <= take_single ? single_en : repeat_en;
      end else if (issue) begin
        cur_ch    <= low_ch;
        remaining <= remaining & ~low_bit;
      end
    end
  end

  // Core controls and interrupt outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      core       <= '0;
      act_q      <= 1'b0;
      single_irq <= 1'b0;
      repeat_irq <= 1'b0;
    end else begin
      act_q          <= activate;
      core.reset     <= soft_reset || (activate && !act_q);
      // power while active with power saver disabled, or while a cycle runs
      core.power_up  <= (activate && power_saver_dis) || (next_state != ASC_IDLE);
      core.start     <= issue && !soft_reset;
      core.channel   <= issue ? low_ch : core.channel;
      single_irq     <= next_single_done;
      repeat_irq     <= next_repeat_done;
    end
  end

  // Last channel started in the running cycle, for the order check
  always_ff @(posedge clk) begin
    if (rst || state == ASC_IDLE) begin
      last_seen <= 1'b0;
      last_ch   <= 4'h0;
    end else if (core.start) begin
      last_seen <= 1'b1;
      last_ch   <= core.channel;
    end
  end

  // Checks
  a_w1c_single_flag: assert property (@(posedge clk) disable iff (rst)
    (w1_sdone && !single_end) |=> !single_done)
    else $error("single done flag not cleared by write of one");
  a_w0_keeps_flag: assert property (@(posedge clk) disable iff (rst)
    (wr_ctl && !bus.wdata[`ASC_BIT_RDONE] && repeat_done && !take_repeat) |=> repeat_done)
    else $error("repeat done flag lost on write of zero");
  a_single_done_set: assert property (@(posedge clk) disable iff (rst)
    single_end |=> single_done && single_irq)
    else $error("single done not set at cycle end");
  a_single_begin_clr: assert property (@(posedge clk) disable iff (rst)
    take_single |=> !single_done)
    else $error("single done not cleared at cycle begin");
  a_repeat_done_set: assert property (@(posedge clk) disable iff (rst)
    repeat_end |=> repeat_done ##0 repeat_irq)
    else $error("repeat done not set at cycle end");
  a_repeat_begin_clr: assert property (@(posedge clk) disable iff (rst)
    take_repeat |=> !repeat_done)
    else $error("repeat done not cleared at cycle begin");
  a_soft_reset_core: assert property (@(posedge clk) disable iff (rst)
    soft_reset |=> core.reset && !core.start)
    else $error("core not held in reset");
  a_start_self_clear: assert property (@(posedge clk) disable iff (rst)
    start_single && !single_req |=> !start_single)
    else $error("start single did not clear itself");
  a_no_start_inactive: assert property (@(posedge clk) disable iff (rst)
    (state == ASC_IDLE && !activate) |=> state == ASC_IDLE && !core.start)
    else $error("conversion launched while inactive");
  a_act_reset_pulse: assert property (@(posedge clk) disable iff (rst)
    (activate && !act_q) |=> core.reset)
    else $error("no core reset on activation");
  a_ascending_order: assert property (@(posedge clk) disable iff (rst)
    (core.start && last_seen) |-> core.channel > last_ch)
    else $error("channels not in ascending order");
  a_ctl_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    $past(bus.rd) && $past(bus.addr) == `ASC_CTL_OFS |-> rdata[31:8] == 24'h0000_00 && !rdata[5])
    else $error("reserved control bits not zero");

  // Arbitration, power and core link checks
  a_single_req_kept: assert property (@(posedge clk) disable iff (rst)
    (single_req && !bus.wdata[`ASC_BIT_SOFTRST] && !soft_reset) |=> single_pend)
    else $error("single start request lost");
  a_repeat_req_kept: assert property (@(posedge clk) disable iff (rst)
    (timer_fire && seq_go && start_repeat) |=> repeat_pend)
    else $error("periodic request lost");
  a_repeat_mode_stop: assert property (@(posedge clk) disable iff (rst)
    !start_repeat |=> !repeat_pend)
    else $error("periodic request pends with repeat mode off");
  a_repeat_follows_single: assert property (@(posedge clk) disable iff (rst)
    (single_end && repeat_pend && !single_pend && seq_go && start_repeat && !wr_ctl) |=> take_repeat)
    else $error("pending repeat cycle not run next");
  a_single_follows_repeat: assert property (@(posedge clk) disable iff (rst)
    (repeat_end && single_pend && seq_go && !wr_ctl) |=> take_single)
    else $error("pending single cycle not run next");
  a_power_saver_off: assert property (@(posedge clk) disable iff (rst)
    (!power_saver_dis && next_state == ASC_IDLE) |=> !core.power_up)
    else $error("core powered while idle with power saving on");
  a_cycle_runs_on: assert property (@(posedge clk) disable iff (rst)
    (state == ASC_WAIT && !soft_reset) |=> state != ASC_IDLE)
    else $error("running cycle abandoned");
  a_core_reset_release: assert property (@(posedge clk) disable iff (rst)
    (!soft_reset && !(activate && !act_q)) |=> !core.reset)
    else $error("core reset not released");
  a_flag_irq_follow: assert property (@(posedge clk) disable iff (rst)
    single_irq == single_done && repeat_irq == repeat_done)
    else $error("interrupt request differs from done flag");

  c_single_cycle: cover property (@(posedge clk) disable iff (rst) take_single ##[1:200] single_end);
  c_repeat_cycle: cover property (@(posedge clk) disable iff (rst) take_repeat ##[1:200] repeat_end);
  c_collision:    cover property (@(posedge clk) disable iff (rst) single_pend && repeat_pend && launch);
  c_act_pulse:    cover property (@(posedge clk) disable iff (rst) activate && !act_q);
  c_follow:       cover property (@(posedge clk) disable iff (rst) single_end ##1 take_repeat);
endmodule

// >>> tb/asc_core_model.sv
// Behavioural model of the converter core behind the sequencing control
`timescale 1ns/1ps
module asc_core_model
  import asc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Link from the control
  input  wire asc_core_req_type core,
  input  wire logic             slow,
  output logic                  conv_done
);
  int cnt = 0;

  initial conv_done = 1'b0;

  // Core reset abandons the channel in flight
  always @(posedge clk) begin
    conv_done <= 1'b0;
    if (rst || core.reset)
      cnt <= 0;
    else if (core.start)
      cnt <= slow ? 20 : 2;
    else if (cnt == 1) begin
      conv_done <= 1'b1;
      cnt <= 0;
    end else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule

// >>> tb/tb_asc_ctrl.sv
// Self-checking testbench of the converter sequencing control
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, e, g)
module tb_asc_ctrl
  import asc_pkg::*;
;
  logic             clk;
  logic             rst;
  logic             slow;
  asc_bus_req_type  bus;
  logic [31:0]      rdata;
  logic             conv_done;
  asc_core_req_type core;
  logic             single_irq;
  logic             repeat_irq;
  int               fail_count = 0;
  int               samples_checked = 0;
  int               cyc = 0;
  int               seed;
  logic [31:0]      exp_rd[$];
  logic [3:0]       exp_ch[$];
  logic [3:0]       rep_ch;
  logic             rd_q = 1'b0;
  logic [7:0]       m;

  asc_ctrl #(.CHANNELS(8), .TICK_CYCLES(4)) dut (
    .clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .conv_done(conv_done),
    .core(core), .single_irq(single_irq), .repeat_irq(repeat_irq));

  asc_core_model model (.clk(clk), .rst(rst), .core(core), .slow(slow), .conv_done(conv_done));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Results of reads and of channel starts are compared against the notes
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_q <= bus.rd;
    if (rd_q && exp_rd.size() > 0)
      `CHK("rdata", exp_rd.pop_front(), rdata);
    if (core.start)
      `CHK("channel", exp_ch.size() ? exp_ch.pop_front() : rep_ch, core.channel);
    if (cyc == 30000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
  endtask

  // Kind 0 single flag, 1 repeat flag, 2 channel start
  task automatic wait_for(input int k);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if ((k == 0 && single_irq === 1'b1) || (k == 1 && repeat_irq === 1'b1) || (k == 2 && core.start === 1'b1))
        break;
    end
    if (i == 3000) begin
      fail_count++;
      $display("wrong value wait %0d exp 1 got 0", k);
    end
  endtask

  task automatic quiet(input int n);
    int s;
    s = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      s += core.start;
    end
    `CHK("starts", 0, s);
  endtask

  task automatic push_m(input logic [7:0] mk);
    for (int i = 0; i < 8; i++)
      if (mk[i])
        exp_ch.push_back(4'(i));
  endtask

  initial begin
    seed = 32'h2f54_e512;
    rst = 1'b1;
    slow = 1'b0;
    bus = '0;
    rep_ch = 4'hf;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h00, 32'hffff_ff20);
    rd(8'h00, 32'h0);
    $display("test reset_values done");
    m = 8'($random(seed)) | 8'h10;
    push_m(m);
    wr(8'h0c, {24'h0, m});
    wr(8'h00, 32'h3);
    #1;
    `CHK("core.reset", 1'b1, core.reset);
    wait_for(0);
    `CHK("left", 0, exp_ch.size());
    rd(8'h00, 32'h81);
    rd(8'h08, {24'h0, m});
    rd(8'h0c, {24'h0, m});
    wr(8'h08, 32'hff);
    rd(8'h08, 32'h0);
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h81);
    push_m(m);
    wr(8'h00, 32'h3);
    wait_for(2);
    `CHK("single_irq", 1'b0, single_irq);
    wait_for(0);
    wr(8'h00, 32'h81);
    rd(8'h00, 32'h1);
    `CHK("single_irq", 1'b0, single_irq);
    $display("test single done");
    rep_ch = 4'($random(seed) & 7);
    wr(8'h10, 32'h1 << rep_ch);
    wr(8'h04, 32'h0001_0002);
    rd(8'h04, 32'h0001_0002);
    wr(8'h00, 32'h5);
    wait_for(1);
    wait_for(2);
    `CHK("repeat_irq", 1'b0, repeat_irq);
    wait_for(1);
    wr(8'h00, 32'h1);
    repeat (60) @(posedge clk);
    quiet(100);
    $display("test repeat done");
    wr(8'h00, 32'h9);
    @(posedge clk);
    #1;
    `CHK("power_up", 1'b1, core.power_up);
    wr(8'h00, 32'h1);
    @(posedge clk);
    #1;
    `CHK("power_up", 1'b0, core.power_up);
    wr(8'h00, 32'h11);
    rd(8'h00, 32'h51);
    `CHK("core.reset", 1'b1, core.reset);
    wr(8'h00, 32'h1);
    @(posedge clk);
    #1;
    `CHK("core.reset", 1'b0, core.reset);
    wr(8'h00, 32'h2);
    quiet(50);
    $display("test reset_power done");
    slow <= 1'b1;
    push_m(8'hff);
    wr(8'h0c, 32'hff);
    wr(8'h00, 32'h3);
    wait_for(2);
    wr(8'h00, 32'h0);
    wait_for(0);
    `CHK("left", 0, exp_ch.size());
    rd(8'h00, 32'hc0);
    quiet(50);
    `CHK("power_up", 1'b0, core.power_up);
    $display("test deactivate done");
    slow <= 1'b0;
    wr(8'h00, 32'hc0);
    wr(8'h04, 32'h0);
    wr(8'h0c, {24'h0, m});
    push_m(m);
    wr(8'h00, 32'h7);
    wait_for(0);
    wait_for(1);
    `CHK("left", 0, exp_ch.size());
    wr(8'h00, 32'h0);
    repeat (60) @(posedge clk);
    $display("test collision done");
    tally_and_finish();
  end
endmodule
